// File: test/fesq_assertions.sv
// Port checker for the flash sequencer
`timescale 1ns/1ps
module fesq_assertions (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        flash_ce_n,
    input wire logic        flash_we_n,
    input wire logic        flash_oe_n,
    input wire logic [17:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    strobe_excl_a: assert property (flash_we_n || flash_oe_n)
        else $error("write and read strobes overlap");
    we_pulse_a: assert property ($fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n)[*8])
        else $error("write pulse too short");
    we_gap_a: assert property ($rose(flash_we_n) |-> flash_we_n[*6])
        else $error("write gap too short");
    dq_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
        else $error("data not driven in write");
    dq_release_a: assert property ($rose(flash_we_n) |=> !flash_dq_oe)
        else $error("data held after write");
    addr_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
        else $error("address or data moved in write");
    rd_clean_a: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe)
        else $error("read with bus driven");
    rd_pulse_a: assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*8])
        else $error("read pulse too short");
endmodule
bind fesq_top fesq_assertions chk_u (.clk(clk), .rstn(rstn), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));

// File: test/fesq_flash_model.sv
// Behavioural flash device answering the sequencer's bus cycles
`timescale 1ns/1ps
module fesq_flash_model #(
    parameter int BUSY = 300
) (
    input  wire logic        clk,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [15:0] d,
    output logic [15:0]      q,
    output logic             rb_n
);
    int          n = 0;
    int          busy = 0;
    bit          ers = 0;
    bit          sus = 0;
    bit          tog = 0;
    logic [15:0] wd = 16'hFFFF;
    initial q = 16'h0000;
    assign rb_n = busy == 0;
    always @(posedge clk) if (busy > 0) busy = busy - 1;
    always @(posedge we_n) begin
        if (ers && busy > 0) begin
            sus = d == 16'h00B0;
            ers = d == 16'h0030;
            busy = ers ? BUSY : 0;
        end else if (sus && d == 16'h0030) begin
            sus = 0;
            ers = 1;
            wd = 16'hFFFF;
            busy = BUSY;
        end else if (n == 8) begin
            wd = d;
            ers = 0;
            busy = BUSY;
            n = 0;
        end else if (n == 2 && d == 16'h00A0) n = 8;
        else if (n == 5 && d == 16'h0030) begin
            wd = 16'hFFFF;
            ers = 1;
            busy = BUSY;
            n = 0;
        end else n = (d == (n % 3 == 0 ? 16'h00AA : n % 3 == 1 ? 16'h0055 : 16'h0080)) ? n + 1 : 0;
    end
    always @(negedge oe_n) begin
        tog = tog ^ (busy > 0);
        q = wd;
        if (busy > 0) q[7:5] = {ers ? 1'b0 : ~wd[7], tog, 1'b0};
    end
    // Released bus must not keep showing the old word
    always @(posedge oe_n) q = ~q;
endmodule

// File: test/tb_flash_erase_program_sequencer.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
module tb_flash_erase_program_sequencer;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [31:0] sw_rdata, v;
    logic        ce_n, we_n, oe_n, dq_oe, rb_n;
    logic [17:0] fa;
    logic [15:0] dq_o, dq_i, dat;
    logic [15:0] exp_q[$];
    int          num_errors = 0;
    int          comparisons = 0;
    initial forever #2.5 clk = ~clk;
    fesq_top #(.LOAD_WIN_CYC(50), .SUSPEND_CYC(20)) dut_u (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_ce_n(ce_n),
        .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
        .flash_dq_i(dq_i), .ready_busy_n(rb_n));
    fesq_flash_model dev_u (.clk(clk), .we_n(we_n), .oe_n(oe_n), .d(dq_o), .q(dq_i), .rb_n(rb_n));
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
        @(posedge clk) sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk) {sw_addr, sw_rd} <= {a, 1'b1};
        @(posedge clk) sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask
    task automatic op(input logic [17:0] a, input logic [15:0] d, input logic [2:0] c);
        wr(fesq_pkg::REG_ADDR, {14'h0, a});
        wr(fesq_pkg::REG_DATA, {16'h0, d});
        wr(fesq_pkg::REG_CTRL, {29'h0, c});
    endtask
    // Wait until the masked status matches; bounded so a hang ends the run
    task automatic wt(input logic [31:0] m, input logic [31:0] e);
        for (int k = 0; k < 4000; k++) begin
            rd(fesq_pkg::REG_STATUS);
            if ((v & m) === e) return;
        end
        num_errors++;
        $display("ERROR t=%0t status wait ran out", $time);
        print_verdict();
    endtask
    task automatic read_back(input logic [17:0] a);
        op(a, 16'h0, fesq_pkg::OP_READ);
        wt(32'h42, 32'h0);
        rd(fesq_pkg::REG_RDATA);
        dat = exp_q.pop_front();
        chk(v, {dat, dat});
    endtask
    initial begin
        void'($urandom(32'h757f));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(4'h9);
        chk(v, 32'h0);
        rd(fesq_pkg::REG_STATUS);
        chk(v & 32'h9E, 32'h0);
        for (int i = 0; i < 3; i++) begin
            dat = 16'($urandom);
            exp_q.push_back(dat);
            op(18'h00100 + 18'(i), dat, fesq_pkg::OP_PROGRAM);
            wt(32'h42, 32'h0);
            chk(v & 32'hC, {28'h0, fesq_pkg::RES_OK, 2'h0});
            read_back(18'h00100 + 18'(i));
        end
        op(18'h10000, 16'h0, fesq_pkg::OP_ERASE);
        wt(32'h42, 32'h40);
        op(18'h20000, 16'h0, fesq_pkg::OP_ADDSEC);
        wt(32'h42, 32'h0);
        chk(v & 32'hC, {28'h0, fesq_pkg::RES_OK, 2'h0});
        exp_q.push_back(16'hFFFF);
        read_back(18'h10000);
        op(18'h30000, 16'h0, fesq_pkg::OP_ERASE);
        wt(32'h42, 32'h40);
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_SUSPEND});
        wt(32'h42, 32'h0);
        chk(v & 32'h10, 32'h10);
        op(18'h00200, 16'($urandom), fesq_pkg::OP_PROGRAM);
        wt(32'h42, 32'h0);
        chk(v & 32'h1C, {27'h0, 1'b1, fesq_pkg::RES_OK, 2'h0});
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_RESUME});
        wt(32'h1, 32'h1);
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_SUSPEND});
        wt(32'h42, 32'h0);
        chk(v & 32'h1C, 32'h10);
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_RESUME});
        wt(32'h52, 32'h0);
        chk(v & 32'hC, {28'h0, fesq_pkg::RES_OK, 2'h0});
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_SUSPEND});
        rd(fesq_pkg::REG_STATUS);
        chk(v & 32'h12, 32'h0);
        op(18'h30000, 16'h0, fesq_pkg::OP_ERASE);
        wt(32'h42, 32'h40);
        wr(fesq_pkg::REG_CTRL, {29'h0, fesq_pkg::OP_RESET});
        wt(32'h52, 32'h0);
        chk(v & 32'h8C, 32'h0);
        print_verdict();
    end
endmodule

// File: verilog/fesq_bus_cycle.sv
// One bus write or read cycle on the flash pins
`timescale 1ns/1ps
module fesq_bus_cycle (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Request
    input  wire logic                   start,
    input  wire logic                   is_write,
    input  wire logic [fesq_pkg::AW-1:0] addr,
    input  wire logic [fesq_pkg::DW-1:0] wdata,
    output logic                        done,
    output logic [fesq_pkg::DW-1:0]      rdata,
    // Flash pins
    output logic                        ce_n,
    output logic                        we_n,
    output logic                        oe_n,
    output logic [fesq_pkg::AW-1:0]      fa,
    output logic [fesq_pkg::DW-1:0]      dq_o,
    output logic                        dq_oe,
    input  wire logic [fesq_pkg::DW-1:0] dq_i
);
    typedef enum logic [1:0] {BC_IDLE, BC_LOW, BC_HIGH} fesq_bc_t;
    fesq_bc_t  st_q;
    logic [7:0] cnt_q;
    logic       wr_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q  <= BC_IDLE;
            cnt_q <= 8'h00;
            wr_q  <= 1'b0;
            ce_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_n  <= 1'b1;
            fa    <= '0;
            dq_o  <= '0;
            dq_oe <= 1'b0;
            done  <= 1'b0;
            rdata <= '0;
        end else begin
            done <= 1'b0;
            case (st_q)
                BC_IDLE: begin
                    if (start) begin
                        // Address set up with both strobes; device latches on fall, data on rise
                        fa    <= addr;
                        dq_o  <= wdata;
                        dq_oe <= is_write;
                        wr_q  <= is_write;
                        ce_n  <= 1'b0;
                        we_n  <= !is_write;
                        oe_n  <= is_write;
                        cnt_q <= is_write ? 8'(fesq_pkg::STROBE_LOW_CYC) : 8'(fesq_pkg::READ_CYC);
                        st_q  <= BC_LOW;
                    end
                end
                BC_LOW: begin
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        if (!wr_q) begin
                            rdata <= dq_i;
                        end
                        ce_n  <= 1'b1;
                        we_n  <= 1'b1;
                        oe_n  <= 1'b1;
                        cnt_q <= 8'(fesq_pkg::STROBE_HI_CYC);
                        st_q  <= BC_HIGH;
                    end
                end
                default: begin
                    // Hold data past the rising edge, then release the bus
                    dq_oe <= 1'b0;
                    if (cnt_q > 8'h01) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        done <= 1'b1;
                        st_q <= BC_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// File: verilog/fesq_pkg.sv
// Constants for the flash erase/program host sequencer
package fesq_pkg;
    localparam int AW = 18;
    localparam int DW = 16;
    localparam logic [15:0] CMD_SETUP   = 16'h0080;
    localparam logic [15:0] CMD_SECTOR  = 16'h0030;
    localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
    localparam logic [15:0] CMD_RESUME  = 16'h0030;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [15:0] CMD_RESET   = 16'h00F0;
    // Status bit positions on the data bus
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TMO_BIT    = 5;
    localparam int TIMER_BIT  = 3;
    // Timing at 200 MHz
    localparam int CLK_PS        = 5000;
    localparam int STROBE_LOW_NS = 50;
    localparam int STROBE_HI_NS  = 30;
    localparam int READ_NS       = 120;
    localparam int LOAD_WIN_US   = 30;
    localparam int SUSPEND_US    = 100;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int STROBE_HI_CYC  = (STROBE_HI_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int READ_CYC       = (READ_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int LOAD_WIN_CYC   = (LOAD_WIN_US * 1000000) / CLK_PS;
    localparam int SUSPEND_CYC    = (SUSPEND_US * 1000000) / CLK_PS;
    // Software port map
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_DATA   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA  = 4'h4;
    // Control opcodes written to the control register
    localparam logic [2:0] OP_ERASE   = 3'h1;
    localparam logic [2:0] OP_PROGRAM = 3'h2;
    localparam logic [2:0] OP_SUSPEND = 3'h3;
    localparam logic [2:0] OP_RESUME  = 3'h4;
    localparam logic [2:0] OP_RESET   = 3'h5;
    localparam logic [2:0] OP_READ    = 3'h6;
    localparam logic [2:0] OP_ADDSEC  = 3'h7;
    // Result codes
    localparam logic [1:0] RES_NONE = 2'h0;
    localparam logic [1:0] RES_OK   = 2'h1;
    localparam logic [1:0] RES_FAIL = 2'h2;
endpackage

// File: verilog/fesq_top.sv
// Host sequencer issuing erase, program, suspend and resume to a parallel flash
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fesq_top #(
    parameter logic [fesq_pkg::AW-1:0] UNLOCK_ADDR1 = 18'h00555,
    parameter logic [fesq_pkg::AW-1:0] UNLOCK_ADDR2 = 18'h002AA,
    parameter logic [fesq_pkg::DW-1:0] UNLOCK_DATA1 = 16'h00AA,
    parameter logic [fesq_pkg::DW-1:0] UNLOCK_DATA2 = 16'h0055,
    parameter int                      LOAD_WIN_CYC = fesq_pkg::LOAD_WIN_CYC,
    parameter int                      SUSPEND_CYC  = fesq_pkg::SUSPEND_CYC
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // Software port
    input  wire logic [3:0]              sw_addr,
    input  wire logic [31:0]             sw_wdata,
    input  wire logic                    sw_wr,
    input  wire logic                    sw_rd,
    output logic [31:0]                  sw_rdata,
    // Flash pins
    output logic                         flash_ce_n,
    output logic                         flash_we_n,
    output logic                         flash_oe_n,
    output logic [fesq_pkg::AW-1:0]      flash_addr,
    output logic [fesq_pkg::DW-1:0]      flash_dq_o,
    output logic                         flash_dq_oe,
    input  wire logic [fesq_pkg::DW-1:0] flash_dq_i,
    input  wire logic                    ready_busy_n
);
    typedef enum logic [2:0] {S_IDLE, S_CMD, S_WAIT, S_POLL, S_TIMER} fesq_state_t;
    typedef enum logic [1:0] {K_NONE, K_ERASE, K_PROG, K_READ} fesq_kind_t;

    fesq_state_t            st_q;
    fesq_kind_t             kind_q;
    logic [2:0]             step_q;
    logic [2:0]             nsteps_q;
    logic [fesq_pkg::AW-1:0] addr_q;
    logic [fesq_pkg::DW-1:0] data_q;
    logic [fesq_pkg::DW-1:0] prev_q;
    logic                   have_prev_q;
    logic [1:0]             result_q;
    logic                   suspended_q;
    logic                   window_q;
    logic                   tmo_seen_q;
    logic [31:0]            win_cnt_q;
    logic [31:0]            spd_cnt_q;
    logic [fesq_pkg::DW-1:0] rd_q;
    logic [fesq_pkg::DW-1:0] last_q;
    logic                   busy_pin_q;
    logic                   sus_req_q;

    logic                   bc_start_q;
    logic                   bc_write_q;
    logic [fesq_pkg::AW-1:0] bc_addr_q;
    logic [fesq_pkg::DW-1:0] bc_wdata_q;
    logic                   bc_done;
    logic [fesq_pkg::DW-1:0] bc_rdata;

    fesq_bus_cycle u_bc (
        .clk      (clk),
        .rstn     (rstn),
        .start    (bc_start_q),
        .is_write (bc_write_q),
        .addr     (bc_addr_q),
        .wdata    (bc_wdata_q),
        .done     (bc_done),
        .rdata    (bc_rdata),
        .ce_n     (flash_ce_n),
        .we_n     (flash_we_n),
        .oe_n     (flash_oe_n),
        .fa       (flash_addr),
        .dq_o     (flash_dq_o),
        .dq_oe    (flash_dq_oe),
        .dq_i     (flash_dq_i)
    );

    // Command step table: address and data of the n-th write
    function automatic logic [fesq_pkg::AW+fesq_pkg::DW-1:0] step_word(
        input fesq_kind_t k, input logic [2:0] s, input logic [fesq_pkg::AW-1:0] a,
        input logic [fesq_pkg::DW-1:0] d);
        logic [fesq_pkg::AW+fesq_pkg::DW-1:0] w;
        w = {UNLOCK_ADDR1, UNLOCK_DATA1};
        if (s == 3'h1 || s == 3'h4) begin
            w = {UNLOCK_ADDR2, UNLOCK_DATA2};
        end else if (s == 3'h2) begin
            w = (k == K_ERASE) ? {UNLOCK_ADDR1, fesq_pkg::CMD_SETUP} : {UNLOCK_ADDR1, fesq_pkg::CMD_PROGRAM};
        end else if (s == 3'h3 && k == K_PROG) begin
            w = {a, d};
        end else if (s == 3'h5) begin
            w = {a, fesq_pkg::CMD_SECTOR};
        end
        return w;
    endfunction

    logic start_erase;
    logic start_prog;
    logic start_single;
    logic sw_op;
    assign sw_op        = sw_wr && sw_addr == fesq_pkg::REG_CTRL && st_q == S_IDLE;
    assign start_erase  = sw_op && sw_wdata[2:0] == fesq_pkg::OP_ERASE && !suspended_q;
    // Program is allowed while suspended, as are resume, read and reset; erase is refused, and add-sector finds the window closed
    assign start_prog   = sw_op && sw_wdata[2:0] == fesq_pkg::OP_PROGRAM;
    assign start_single = sw_op && (sw_wdata[2:0] == fesq_pkg::OP_RESET || sw_wdata[2:0] == fesq_pkg::OP_READ);

    logic tog_stable;
    logic poll_ok;
    assign tog_stable = have_prev_q && prev_q[fesq_pkg::TOGGLE_BIT] == bc_rdata[fesq_pkg::TOGGLE_BIT];
    // Program completion needs bits 7 and 6 equal to written data
    assign poll_ok = (kind_q == K_PROG)
        ? (bc_rdata[fesq_pkg::POLL_BIT] == data_q[fesq_pkg::POLL_BIT] &&
           bc_rdata[fesq_pkg::TOGGLE_BIT] == data_q[fesq_pkg::TOGGLE_BIT])
        : bc_rdata[fesq_pkg::POLL_BIT];

    // Software registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            addr_q <= '0;
            data_q <= '0;
        end else if (sw_wr && st_q == S_IDLE) begin
            if (sw_addr == fesq_pkg::REG_ADDR) begin
                addr_q <= sw_wdata[fesq_pkg::AW-1:0];
            end else if (sw_addr == fesq_pkg::REG_DATA) begin
                data_q <= sw_wdata[fesq_pkg::DW-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sw_rdata <= 32'h00000000;
        end else if (sw_rd) begin
            if (sw_addr == fesq_pkg::REG_ADDR) begin
                sw_rdata <= {14'h0000, addr_q};
            end else if (sw_addr == fesq_pkg::REG_DATA) begin
                sw_rdata <= {16'h0000, data_q};
            end else if (sw_addr == fesq_pkg::REG_STATUS) begin
                sw_rdata <= {24'h000000, busy_pin_q, window_q, tmo_seen_q, suspended_q,
                             result_q, st_q != S_IDLE, st_q == S_POLL};
            end else if (sw_addr == fesq_pkg::REG_RDATA) begin
                sw_rdata <= {last_q, rd_q};
            end else begin
                sw_rdata <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy_pin_q <= 1'b0;
        end else begin
            busy_pin_q <= !ready_busy_n;
        end
    end

    // A suspend during active erase waits for the poll read in flight
    always_ff @(posedge clk) begin
        if (!rstn || st_q != S_POLL) begin
            sus_req_q <= 1'b0;
        end else if (sw_wr && sw_addr == fesq_pkg::REG_CTRL && sw_wdata[2:0] == fesq_pkg::OP_SUSPEND
                     && kind_q == K_ERASE) begin
            sus_req_q <= 1'b1;
        end
    end

    // Main sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q        <= S_IDLE;
            kind_q      <= K_NONE;
            step_q      <= 3'h0;
            nsteps_q    <= 3'h0;
            prev_q      <= '0;
            have_prev_q <= 1'b0;
            result_q    <= fesq_pkg::RES_NONE;
            suspended_q <= 1'b0;
            window_q    <= 1'b0;
            tmo_seen_q  <= 1'b0;
            win_cnt_q   <= 32'h00000000;
            spd_cnt_q   <= 32'h00000000;
            rd_q        <= '0;
            last_q      <= '0;
            bc_start_q  <= 1'b0;
            bc_write_q  <= 1'b0;
            bc_addr_q   <= '0;
            bc_wdata_q  <= '0;
        end else begin
            bc_start_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (start_erase || start_prog) begin
                        kind_q      <= start_erase ? K_ERASE : K_PROG;
                        nsteps_q    <= start_erase ? 3'h6 : 3'h4;
                        step_q      <= 3'h0;
                        result_q    <= fesq_pkg::RES_NONE;
                        tmo_seen_q  <= 1'b0;
                        // Any other command ends the device's load window
                        window_q    <= 1'b0;
                        {bc_addr_q, bc_wdata_q} <= step_word(start_erase ? K_ERASE : K_PROG, 3'h0, addr_q, data_q);
                        bc_write_q  <= 1'b1;
                        bc_start_q  <= 1'b1;
                        st_q        <= S_CMD;
                    end else if (start_single) begin
                        kind_q     <= sw_wdata[2:0] == fesq_pkg::OP_READ ? K_READ : K_NONE;
                        bc_write_q <= sw_wdata[2:0] != fesq_pkg::OP_READ;
                        bc_addr_q  <= addr_q;
                        bc_wdata_q <= fesq_pkg::CMD_RESET;
                        bc_start_q <= 1'b1;
                        if (sw_wdata[2:0] == fesq_pkg::OP_RESET) begin
                            suspended_q <= 1'b0;
                            window_q    <= 1'b0;
                        end
                        st_q <= S_WAIT;
                    end else if (sw_op && sw_wdata[2:0] == fesq_pkg::OP_ADDSEC && window_q) begin
                        // Extra sector address inside the load window
                        kind_q     <= K_ERASE;
                        bc_write_q <= 1'b1;
                        {bc_addr_q, bc_wdata_q} <= {addr_q, fesq_pkg::CMD_SECTOR};
                        bc_start_q <= 1'b1;
                        st_q       <= S_WAIT;
                    end else if (sw_op && sw_wdata[2:0] == fesq_pkg::OP_RESUME && suspended_q) begin
                        kind_q      <= K_ERASE;
                        suspended_q <= 1'b0;
                        result_q    <= fesq_pkg::RES_NONE;
                        tmo_seen_q  <= 1'b0;
                        bc_write_q  <= 1'b1;
                        {bc_addr_q, bc_wdata_q} <= {addr_q, fesq_pkg::CMD_RESUME};
                        bc_start_q  <= 1'b1;
                        st_q        <= S_WAIT;
                    end else if (sw_op && sw_wdata[2:0] == fesq_pkg::OP_SUSPEND && kind_q == K_ERASE
                                 && result_q == fesq_pkg::RES_NONE) begin
                        // Suspend sent while erase has no result yet, even if already suspended
                        bc_write_q  <= 1'b1;
                        {bc_addr_q, bc_wdata_q} <= {addr_q, fesq_pkg::CMD_SUSPEND};
                        bc_start_q  <= 1'b1;
                        suspended_q <= 1'b1;
                        window_q    <= 1'b0;
                        spd_cnt_q   <= window_q ? 32'h00000001 : 32'(SUSPEND_CYC);
                        st_q        <= S_WAIT;
                    end
                    if (window_q && !sw_op) begin
                        if (win_cnt_q > 32'h00000001) begin
                            win_cnt_q <= win_cnt_q - 32'h00000001;
                        end else begin
                            // Window closed, device now erasing on its own
                            window_q <= 1'b0;
                            st_q     <= S_POLL;
                            have_prev_q <= 1'b0;
                            bc_write_q <= 1'b0;
                            bc_addr_q  <= addr_q;
                            bc_start_q <= 1'b1;
                        end
                    end
                end
                S_CMD: begin
                    if (bc_done) begin
                        if (step_q + 3'h1 == nsteps_q) begin
                            // Poll valid after final strobe rise
                            have_prev_q <= 1'b0;
                            bc_write_q  <= 1'b0;
                            bc_addr_q   <= addr_q;
                            if (kind_q == K_ERASE) begin
                                window_q  <= 1'b1;
                                win_cnt_q <= 32'(LOAD_WIN_CYC);
                                st_q      <= S_IDLE;
                            end else begin
                                bc_start_q <= 1'b1;
                                st_q       <= S_POLL;
                            end
                        end else begin
                            step_q     <= step_q + 3'h1;
                            {bc_addr_q, bc_wdata_q} <= step_word(kind_q, step_q + 3'h1, addr_q, data_q);
                            bc_start_q <= 1'b1;
                        end
                    end
                end
                S_WAIT: begin
                    if (bc_done) begin
                        if (kind_q == K_READ) begin
                            rd_q <= bc_rdata;
                        end
                        if (kind_q == K_ERASE && bc_wdata_q == fesq_pkg::CMD_SECTOR && !suspended_q
                            && bc_write_q && !window_q) begin
                            // Resume: poll the erase again
                            bc_write_q  <= 1'b0;
                            have_prev_q <= 1'b0;
                            bc_start_q  <= 1'b1;
                            st_q        <= S_POLL;
                        end else if (kind_q == K_ERASE && bc_wdata_q == fesq_pkg::CMD_SECTOR && window_q) begin
                            win_cnt_q <= 32'(LOAD_WIN_CYC);
                            st_q      <= S_IDLE;
                        end else if (spd_cnt_q != 32'h00000000) begin
                            st_q <= S_TIMER;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_TIMER: begin
                    // Wait out worst-case suspend latency
                    if (spd_cnt_q > 32'h00000001) begin
                        spd_cnt_q <= spd_cnt_q - 32'h00000001;
                    end else begin
                        spd_cnt_q <= 32'h00000000;
                        st_q      <= S_IDLE;
                    end
                end
                default: begin
                    if (bc_done) begin
                        last_q      <= bc_rdata;
                        prev_q      <= bc_rdata;
                        have_prev_q <= 1'b1;
                        if (bc_rdata[fesq_pkg::TMO_BIT]) begin
                            tmo_seen_q <= 1'b1;
                        end
                        if (tog_stable && poll_ok) begin
                            result_q <= fesq_pkg::RES_OK;
                            kind_q   <= K_NONE;
                            st_q     <= S_IDLE;
                        end else if (tmo_seen_q && have_prev_q && !tog_stable) begin
                            // Toggling after timeout: failed, software issues reset
                            result_q <= fesq_pkg::RES_FAIL;
                            kind_q   <= K_NONE;
                            st_q     <= S_IDLE;
                        end else if (sus_req_q) begin
                            // Erase still running: suspend, then wait out its latency
                            bc_write_q  <= 1'b1;
                            {bc_addr_q, bc_wdata_q} <= {addr_q, fesq_pkg::CMD_SUSPEND};
                            bc_start_q  <= 1'b1;
                            suspended_q <= 1'b1;
                            spd_cnt_q   <= 32'(SUSPEND_CYC);
                            st_q        <= S_WAIT;
                        end else begin
                            bc_start_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule
